// File: logic/timer8_pkg.sv
// constants and types shared by the 8-bit waveform timer
`default_nettype none
package timer8_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register bus
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_COMPARE = 8'h08;
   localparam logic [7:0] OFF_FLAGS = 8'h0C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   ////////////////////////////////////////////////////////////////////////
   // control word and flag register fields
   localparam int unsigned CS_LSB = 0;
   localparam int unsigned COM_LSB = 3;
   localparam int unsigned WGM_LSB = 5;
   localparam int unsigned FORCE_BIT = 7;
   localparam int unsigned FLAG_CMP_BIT = 0;
   localparam int unsigned FLAG_OVF_BIT = 1;
   ////////////////////////////////////////////////////////////////////////
   // counter values
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_BELOW_MAX = 8'hFE;
   ////////////////////////////////////////////////////////////////////////
   // waveform and output modes
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PHASE = 2'h1;
   localparam logic [1:0] WGM_CTC = 2'h2;
   localparam logic [1:0] WGM_FAST = 2'h3;
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   ////////////////////////////////////////////////////////////////////////
   // clock select and prescale masks (divide by 1, 8, 64, 256, 1024)
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam logic [9:0] PS_MASK_8 = 10'h007;
   localparam logic [9:0] PS_MASK_64 = 10'h03F;
   localparam logic [9:0] PS_MASK_256 = 10'h0FF;
   localparam logic [9:0] PS_MASK_1024 = 10'h3FF;
   localparam logic [9:0] PS_STEP = 10'h001;

   typedef enum logic [3:0] {
      MODE_NORMAL = 4'b0001,
      MODE_PHASE = 4'b0010,
      MODE_CTC = 4'b0100,
      MODE_FAST = 4'b1000
   } mode_e;
endpackage
`default_nettype wire

// File: logic/timer8_prescale.sv
// prescaler that turns the clock into a one-cycle timer tick
`default_nettype none
module timer8_prescale
   import timer8_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic [2:0] clock_select,
   input wire logic ext_count_pin,
   // tick
   output logic timer_tick
);
   typedef struct packed {
      logic [9:0] div;
      logic pin;
      logic tick;
   } ps_s;

   ps_s s_q;
   ps_s s_d;

   function automatic logic mask_hit(input logic [9:0] v,
                                     input logic [9:0] m);
      return (v & m) == m;
   endfunction

   // free-running divider; all taps share it so changing the rate
   // never waits for a restart
   always_comb begin
      s_d = s_q;
      s_d.div = s_q.div + PS_STEP;
      s_d.pin = ext_count_pin;
      case (clock_select)
         CS_STOP: s_d.tick = 1'b0;
         CS_DIV1: s_d.tick = 1'b1;
         CS_DIV8: s_d.tick = mask_hit(s_q.div, PS_MASK_8);
         CS_DIV64: s_d.tick = mask_hit(s_q.div, PS_MASK_64);
         CS_DIV256: s_d.tick = mask_hit(s_q.div, PS_MASK_256);
         CS_DIV1024: s_d.tick = mask_hit(s_q.div, PS_MASK_1024);
         CS_EXT_FALL: s_d.tick = s_q.pin && !ext_count_pin;
         CS_EXT_RISE: s_d.tick = !s_q.pin && ext_count_pin;
         default: s_d.tick = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign timer_tick = s_q.tick;
endmodule // timer8_prescale
`default_nettype wire

// File: logic/timer8_waveform.sv
// 8-bit timer with one compare channel, pwm modes, axi4-lite registers
`default_nettype none
module timer8_waveform
   import timer8_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external count pin and waveform pin
   input wire logic ext_count_pin,
   output logic waveform_output,
   output logic waveform_connect
);
   typedef struct packed {
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [2:0] cs;
      logic [1:0] com;
      logic [1:0] wgm;
      logic [7:0] cnt;
      logic [7:0] ocr;
      logic [7:0] ocr_buf;
      logic dir_up;
      logic block;
      logic cmp_flag;
      logic ovf_flag;
      logic out;
   } state_s;

   localparam state_s STATE_RST = '{dir_up: 1'b1, default: '0};

   state_s s_q;
   state_s s_d;
   logic timer_tick;
   logic match;
   logic wr_go;
   logic wr_ctrl;
   logic wr_cnt;
   logic wr_cmp;
   logic wr_flags;
   logic set_cmp;
   logic set_ovf;
   mode_e mode;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic mode_e mode_of(input logic [1:0] w);
      case (w)
         WGM_PHASE: return MODE_PHASE;
         WGM_CTC: return MODE_CTC;
         WGM_FAST: return MODE_FAST;
         default: return MODE_NORMAL;
      endcase
   endfunction

   function automatic logic nonpwm_act(input logic o, input logic [1:0] c);
      case (c)
         COM_TOGGLE: return !o;
         COM_CLEAR: return 1'b0;
         COM_SET: return 1'b1;
         default: return o;
      endcase
   endfunction

   function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
      return a[ADDR_W-1:2] == off[ADDR_W-1:2];
   endfunction

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      return is_reg(a, OFF_CTRL) || is_reg(a, OFF_COUNT) ||
             is_reg(a, OFF_COMPARE) || is_reg(a, OFF_FLAGS);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // tick source; counting runs on clk with the tick as an enable
   timer8_prescale u_prescale (
      .clk(clk),
      .rst_b(rst_b),
      .clock_select(s_q.cs),
      .ext_count_pin(ext_count_pin),
      .timer_tick(timer_tick)
   );

   assign mode = mode_of(s_q.wgm);
   // a counter write masks the compare on the following tick
   assign match = (s_q.cnt == s_q.ocr) && !s_q.block;
   assign wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
   assign wr_ctrl = wr_go && s_q.w_lane0 && is_reg(s_q.aw_addr, OFF_CTRL);
   assign wr_cnt = wr_go && s_q.w_lane0 && is_reg(s_q.aw_addr, OFF_COUNT);
   assign wr_cmp = wr_go && s_q.w_lane0 && is_reg(s_q.aw_addr, OFF_COMPARE);
   assign wr_flags = wr_go && s_q.w_lane0 && is_reg(s_q.aw_addr, OFF_FLAGS);

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      set_cmp = 1'b0;
      set_ovf = 1'b0;
      // bus: address and data are taken in either order
      if (s_axi_awvalid && !s_q.aw_have) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_have) begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata[7:0];
         s_d.w_lane0 = s_axi_wstrb[0];
      end
      if (wr_go) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = addr_ok(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_d.rdata = 8'h00;
         if (is_reg(s_axi_araddr, OFF_CTRL)) begin
            s_d.rdata = {1'b0, s_q.wgm, s_q.com, s_q.cs};
         end else if (is_reg(s_axi_araddr, OFF_COUNT)) begin
            s_d.rdata = s_q.cnt;
         end else if (is_reg(s_axi_araddr, OFF_COMPARE)) begin
            s_d.rdata = s_q.ocr_buf;
         end else if (is_reg(s_axi_araddr, OFF_FLAGS)) begin
            s_d.rdata = {6'h00, s_q.ovf_flag, s_q.cmp_flag};
         end
      end

      // counting, flags and waveform on each tick
      if (timer_tick) begin
         s_d.block = 1'b0;
         if (match) begin
            set_cmp = 1'b1;
         end
         case (mode)
            MODE_NORMAL: begin
               s_d.cnt = s_q.cnt + CNT_ONE;
               set_ovf = (s_q.cnt == CNT_MAX);
               if (match) begin
                  s_d.out = nonpwm_act(s_q.out, s_q.com);
               end
            end
            MODE_CTC: begin
               // top is the live compare value; a top written below
               // the count is missed until the 8-bit wrap
               if (match) begin
                  s_d.cnt = CNT_BOTTOM;
                  s_d.out = nonpwm_act(s_q.out, s_q.com);
               end else begin
                  s_d.cnt = s_q.cnt + CNT_ONE;
               end
               set_ovf = (s_q.cnt == CNT_MAX) && !match;
            end
            MODE_FAST: begin
               s_d.cnt = s_q.cnt + CNT_ONE;
               if (match && !(s_q.ocr == CNT_MAX && s_q.com[1])) begin
                  case (s_q.com)
                     COM_TOGGLE: s_d.out = !s_q.out;
                     COM_CLEAR: s_d.out = 1'b0;
                     COM_SET: s_d.out = 1'b1;
                     default: s_d.out = s_q.out;
                  endcase
               end
               if (s_q.cnt == CNT_MAX) begin
                  set_ovf = 1'b1;
                  s_d.ocr = s_q.ocr_buf;
                  if (s_q.com[1]) begin
                     s_d.out = !s_q.com[0];
                  end
               end
            end
            MODE_PHASE: begin
               if (match && !(s_q.ocr == CNT_MAX && s_q.com[1]) &&
                   s_q.com[1]) begin
                  // up-count match gives com[0], down-count the inverse
                  s_d.out = s_q.dir_up ? s_q.com[0] : !s_q.com[0];
               end
               if (s_q.dir_up) begin
                  if (s_q.cnt == CNT_MAX) begin
                     s_d.dir_up = 1'b0;
                     s_d.cnt = CNT_BELOW_MAX;
                     s_d.ocr = s_q.ocr_buf;
                     if (s_q.com[1]) begin
                        // top level keeps the period symmetric
                        s_d.out = (s_q.ocr_buf == CNT_MAX) ?
                                  !s_q.com[0] : s_q.com[0];
                     end
                  end else begin
                     s_d.cnt = s_q.cnt + CNT_ONE;
                  end
               end else if (s_q.cnt == CNT_ONE || s_q.cnt == CNT_BOTTOM) begin
                  s_d.cnt = CNT_BOTTOM;
                  s_d.dir_up = 1'b1;
                  set_ovf = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt - CNT_ONE;
               end
            end
            default: s_d.cnt = s_q.cnt;
         endcase
      end

      // software writes; they win over the tick's counter update
      if (wr_ctrl) begin
         s_d.cs = s_q.w_data[CS_LSB +: 3];
         s_d.com = s_q.w_data[COM_LSB +: 2];
         s_d.wgm = s_q.w_data[WGM_LSB +: 2];
         // force strobe: output only, no flag and no clear
         if (s_q.w_data[FORCE_BIT] && !s_q.wgm[0]) begin
            s_d.out = nonpwm_act(s_q.out, s_q.w_data[COM_LSB +: 2]);
         end
      end
      if (wr_cnt) begin
         s_d.cnt = s_q.w_data;
         s_d.block = 1'b1;
      end
      if (wr_cmp) begin
         s_d.ocr_buf = s_q.w_data;
         if (!s_q.wgm[0]) begin
            s_d.ocr = s_q.w_data;
         end
      end
      // write one to clear; a same-cycle hardware set wins
      if (wr_flags) begin
         s_d.cmp_flag = s_q.cmp_flag && !s_q.w_data[FLAG_CMP_BIT];
         s_d.ovf_flag = s_q.ovf_flag && !s_q.w_data[FLAG_OVF_BIT];
      end
      s_d.cmp_flag = s_d.cmp_flag || set_cmp;
      s_d.ovf_flag = s_d.ovf_flag || set_ovf;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign s_axi_awready = !s_q.aw_have;
   assign s_axi_wready = !s_q.w_have;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = {24'h000000, s_q.rdata};
   assign s_axi_rresp = s_q.rresp;
   assign waveform_output = s_q.out;
   // pin direction stays with the port logic outside
   assign waveform_connect = (s_q.com != COM_OFF);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic ctc_go;
   logic fast_top;
   logic pc_top;
   assign ctc_go = timer_tick && mode == MODE_CTC && !wr_cnt && !wr_ctrl;
   assign fast_top = timer_tick && mode == MODE_FAST && !wr_cnt &&
                     !wr_ctrl && s_q.cnt == CNT_MAX;
   assign pc_top = timer_tick && mode == MODE_PHASE && !wr_cnt &&
                   !wr_ctrl && s_q.dir_up && s_q.cnt == CNT_MAX;

   sequence pc_at_top;
      pc_top;
   endsequence
   sequence pc_turned;
      s_q.cnt == CNT_BELOW_MAX && !s_q.dir_up;
   endsequence

   a_ctc_clear: assert property (
      ctc_go && match |=> s_q.cnt == CNT_BOTTOM && s_q.cmp_flag)
      else $error("ctc match did not clear the counter");
   a_cmp_flag_set: assert property (
      timer_tick && match |=> s_q.cmp_flag)
      else $error("compare flag missing after match");
   a_ctc_direct: assert property (
      wr_cmp && !s_q.wgm[0] |=> s_q.ocr == $past(s_q.w_data))
      else $error("ctc compare write was not immediate");
   a_ctc_toggle: assert property (
      ctc_go && match && s_q.com == COM_TOGGLE && !wr_cmp
      |=> waveform_output != $past(waveform_output))
      else $error("ctc toggle missed");
   a_ctc_ovf: assert property (
      ctc_go && !match && s_q.cnt == CNT_MAX
      |=> s_q.cnt == CNT_BOTTOM && s_q.ovf_flag)
      else $error("ctc wrap without overflow flag");
   a_fast_wrap: assert property (
      fast_top |=> s_q.cnt == CNT_BOTTOM && s_q.ovf_flag)
      else $error("fast pwm did not wrap with overflow");
   a_fast_bottom: assert property (
      fast_top && s_q.com == COM_CLEAR |=> waveform_output)
      else $error("non-inverted fast pwm not set at bottom");
   a_fast_load: assert property (
      fast_top && !wr_cmp |=> s_q.ocr == $past(s_q.ocr_buf))
      else $error("fast pwm compare not loaded at bottom");
   a_pwm_hold: assert property (
      timer_tick && s_q.wgm[0] && s_q.cnt != CNT_MAX && !wr_ctrl
      |=> s_q.ocr == $past(s_q.ocr))
      else $error("pwm compare changed off the boundary");
   a_pc_turn: assert property (
      pc_at_top |=> pc_turned)
      else $error("phase correct did not turn at max");
   a_pc_bottom: assert property (
      timer_tick && mode == MODE_PHASE && !s_q.dir_up && !wr_cnt &&
      !wr_ctrl && s_q.cnt == CNT_ONE
      |=> s_q.cnt == CNT_BOTTOM && s_q.dir_up && s_q.ovf_flag)
      else $error("phase correct bottom missed overflow");
   a_pc_uplevel: assert property (
      pc_top && s_q.com[1] && s_q.ocr_buf != CNT_MAX && !wr_cmp
      |=> waveform_output == $past(s_q.com[0]))
      else $error("phase correct top level wrong");
   a_flag_set_wins: assert property (
      wr_flags && set_cmp |=> s_q.cmp_flag)
      else $error("flag set lost against clear");
endmodule // timer8_waveform
`default_nettype wire

// File: testbench/pin_load_model.sv
// load model for the waveform pin: pad follows the timer or a pull-up
`default_nettype none
module pin_load_model (
   // from the timer
   input wire logic waveform_output,
   input wire logic waveform_connect,
   // pad level seen by the load
   output logic pin_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // pad driver only enabled once the output is routed; pull-up otherwise
   assign pin_level = waveform_connect ? waveform_output : 1'b1;
endmodule // pin_load_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the 8-bit waveform timer
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   fail_count++; $display("Error t=%0t got %0h exp %0h", $time, g, e); \
   end end
module tb
   import timer8_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   ////////////////////////////////////////////////////////////////////////
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic ext_pin = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, waveform_output, waveform_connect, pin_level;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int fail_count = 0;
   int samples_checked = 0;
   always #2.5 clk = ~clk;
   timer8_waveform uut (.clk(clk), .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .ext_count_pin(ext_pin),
      .waveform_output(waveform_output),
      .waveform_connect(waveform_connect));
   pin_load_model load (.waveform_output(waveform_output),
      .waveform_connect(waveform_connect), .pin_level(pin_level));
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic fail_wait();
      fail_count++;
      final_report();
   endtask
   // each channel released only at the edge its ready is seen high
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                         output logic [1:0] r);
      int n;
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (n == 100) fail_wait();
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [7:0] d,
                         output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (n == 100) fail_wait();
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      `CHK(r, RESP_OKAY)
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [1:0] r;
      axi_rd(a, d, r);
      `CHK(r, RESP_OKAY)
   endtask
   // stop first so the compare write lands straight in the active copy
   task automatic setup(input logic [7:0] cmp, input logic [7:0] ctrl);
      wr(OFF_CTRL, 8'h00);
      wr(OFF_COUNT, 8'h00);
      wr(OFF_COMPARE, cmp);
      wr(OFF_FLAGS, 8'h03);
      wr(OFF_CTRL, ctrl);
   endtask
   task automatic wait_lvl(input logic lvl, output int cnt);
      cnt = 0;
      while (waveform_output !== lvl) begin
         @(posedge clk);
         cnt++;
         if (cnt > 5000) fail_wait();
      end
   endtask
   // skips a partial period, then times one high and one low phase
   task automatic chk_wave(input int hi_e, input int per_e);
      int c;
      int hi;
      int lo;
      wait_lvl(1'b0, c);
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
      `CHK(hi, hi_e)
      `CHK(hi + lo, per_e)
   endtask
   task automatic const_lvl(input logic [7:0] cmp, input logic [7:0] ctrl,
                            input logic lvl);
      int n;
      int bad;
      bad = 0;
      setup(cmp, ctrl);
      repeat (600) @(posedge clk);
      for (n = 0; n < 600; n++) begin
         @(posedge clk);
         if (waveform_output !== lvl) bad++;
      end
      `CHK(bad, 0)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      logic [7:0] v;
      logic [1:0] r;
      int n;
      `CHK(waveform_output, 1'b0)
      `CHK(pin_level, 1'b1)
      for (n = 0; n < 4; n++) begin
         axi_rd(8'(n * 4), v, r);
         `CHK(v, 8'h00)
      end
      axi_rd(8'h10, v, r);
      `CHK(r, RESP_SLVERR)
      axi_wr(8'h10, 8'h55, r);
      `CHK(r, RESP_SLVERR)
      $display("test reset done");
   endtask
   task automatic test_ctc();
      logic [7:0] v;
      setup(8'h03, 8'h49);
      chk_wave(4, 8);
      `CHK(pin_level, waveform_output)
      rd(OFF_FLAGS, v);
      `CHK(v[FLAG_CMP_BIT], 1'b1)
      `CHK(v[FLAG_OVF_BIT], 1'b0)
      rd(OFF_COUNT, v);
      `CHK(v <= 8'h03, 1'b1)
      setup(8'h03, 8'h4A);
      chk_wave(32, 64);
      // top of one keeps each slow rate inside the wait bound
      setup(8'h01, 8'h4B);
      chk_wave(128, 256);
      setup(8'h01, 8'h4C);
      chk_wave(512, 1024);
      setup(8'h01, 8'h4D);
      chk_wave(2048, 4096);
      wr(OFF_CTRL, 8'h40);
      wr(OFF_COUNT, 8'h10);
      wr(OFF_COMPARE, 8'h05);
      wr(OFF_FLAGS, 8'h03);
      wr(OFF_CTRL, 8'h41);
      repeat (100) @(posedge clk);
      rd(OFF_COUNT, v);
      `CHK(v > 8'h10, 1'b1)
      repeat (300) @(posedge clk);
      rd(OFF_FLAGS, v);
      `CHK(v[FLAG_OVF_BIT], 1'b1)
      $display("test ctc done");
   endtask
   task automatic test_fast();
      logic [7:0] v;
      setup(8'h40, 8'h71);
      chk_wave(65, 256);
      rd(OFF_FLAGS, v);
      `CHK(v[FLAG_OVF_BIT], 1'b1)
      wr(OFF_COMPARE, 8'h80);
      chk_wave(129, 256);
      setup(8'h40, 8'h79);
      chk_wave(191, 256);
      setup(8'h40, 8'h69);
      chk_wave(256, 512);
      setup(8'h00, 8'h71);
      chk_wave(1, 256);
      const_lvl(8'hFF, 8'h71, 1'b1);
      $display("test fast done");
   endtask
   task automatic test_phase();
      logic [7:0] v;
      setup(8'h40, 8'h31);
      chk_wave(128, 510);
      rd(OFF_FLAGS, v);
      `CHK(v[FLAG_OVF_BIT], 1'b1)
      setup(8'h40, 8'h39);
      chk_wave(382, 510);
      const_lvl(8'h00, 8'h31, 1'b0);
      const_lvl(8'hFF, 8'h31, 1'b1);
      const_lvl(8'hFF, 8'h39, 1'b0);
      $display("test phase done");
   endtask
   // two rising pin edges give one match at top one; then a forced match
   task automatic test_force_ext();
      logic [7:0] v;
      logic lvl;
      int n;
      setup(8'h01, 8'h4F);
      lvl = waveform_output;
      for (n = 0; n < 4; n++) begin
         ext_pin <= ~ext_pin;
         repeat (4) @(posedge clk);
      end
      `CHK(waveform_output, ~lvl)
      wr(OFF_FLAGS, 8'h03);
      wr(OFF_CTRL, 8'hC8);
      `CHK(waveform_output, lvl)
      rd(OFF_FLAGS, v);
      `CHK(v[FLAG_CMP_BIT], 1'b0)
      rd(OFF_CTRL, v);
      `CHK(v, 8'h48)
      $display("test force ext done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      test_reset();
      test_ctc();
      test_fast();
      test_phase();
      test_force_ext();
      final_report();
   end
endmodule // tb
`default_nettype wire
